// [rtl/fsc_pkg.sv]
// Constants, encodings and types of the fail-safe clock and power block
package fsc_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_CFG  = 8'h00;
  localparam logic [7:0] ADDR_INTC = 8'h04;
  localparam logic [7:0] ADDR_OSCC = 8'h08;
  localparam logic [7:0] ADDR_TUNE = 8'h0c;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLE_SECOND = 8'h10;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAG_SECOND = 8'h14;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_PRIORITY_SECOND = 8'h18;
  // Reset values
  localparam logic [7:0] RST_CFG  = 8'h00;
  localparam logic [7:0] RST_INTC = 8'h00;
  localparam logic [7:0] RST_OSCC = 8'h30;
  localparam logic [7:0] RST_TUNE = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLE_SECOND = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAG_SECOND = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_PRIORITY_SECOND = 8'hff;
  // Field positions
  localparam int CFG_TWO_SPEED_ENABLE_FUSE  = 7;
  localparam int CFG_MONITOR_ENABLE_FUSE = 6;
  localparam int OSC_IDLE_ON_SLEEP = 7;
  localparam int OSC_SOURCE_SELECT_UPPER  = 1;
  localparam int OSC_SCS0  = 0;
  localparam int OSCF_BIT  = 7;
  // Primary oscillator configuration codes (crystal kinds need the timer)
  localparam logic [3:0] FOSC_LP    = 4'h0;
  localparam logic [3:0] FOSC_XT    = 4'h1;
  localparam logic [3:0] FOSC_HS    = 4'h2;
  localparam logic [3:0] FOSC_HIGH_SPEED_MULTIPLIED_MODE = 4'h6;
  // Bit positions of the sampled clock levels
  localparam int B_PRI = 0;
  localparam int B_LF  = 3;
  // Timing counts
  localparam int LF_DIV     = 64;
  localparam int OST_CYCLES = 1024;
  localparam logic [4:0] LF_HALF_LAST = 5'(LF_DIV / 2 - 1);
  localparam logic [9:0] OST_LAST     = 10'(OST_CYCLES - 1);
  localparam logic       EDGE_LAST    = 1'b1;

  typedef enum logic [1:0] {
    SRC_PRI = 2'b00, SRC_SEC = 2'b01, SRC_INT = 2'b10
  } fsc_src_t;
  typedef enum logic [2:0] {
    SW_IDLE = 3'b000, SW_READY = 3'b001, SW_OLD = 3'b010,
    SW_HOLD = 3'b011, SW_NEW = 3'b100, SW_REL = 3'b101
  } fsc_sw_t;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00, PWR_IDLE = 2'b01, PWR_SLEEP = 2'b10
  } fsc_pwr_t;

  function automatic logic fsc_needs_ost(input logic [3:0] fosc);
    return (fosc == FOSC_LP) || (fosc == FOSC_XT) ||
           (fosc == FOSC_HS) || (fosc == FOSC_HIGH_SPEED_MULTIPLIED_MODE);
  endfunction
endpackage

// [rtl/fsc_top.sv]
// Fail-safe clock monitor, clock switch and power-mode selector
// Overview of operation
// - Monitor works only with the enable fuse set, for every external mode.
// - Failures are flagged only after the start-up timer has expired.
// - Sample clock is the low-frequency internal clock divided by 64.
// - Detector latch sets on primary falling edge, clears on sample rise.
// - Failure when a whole sample half-period passes with no primary fall.
// - On failure switch to internal clock and set the clock-fail flag.
// - Interrupt request only when flag and its enable are both set.
// - After failure stay on internal clock; never return automatically.
// - Fallback internal frequency comes from the internal frequency field.
// - Fail-safe state clears only by reset, sleep or toggling upper select bit.
// - Each clearing restarts the timer; run on internal clock meanwhile.
// - Timer expiry clears fail-safe state and switches to external clock.
// - Software clears the flag without first clearing fail-safe state.
// - External clock and RC modes skip the start-up timer.
// - Enabled monitor also enables two-speed start-up.
// - Detector idle during start-up; ready bit shows switchover done.
// - Select 00 primary, 01 secondary, 1x internal oscillator block.
// - Switch at once to a running source, else wait for it.
// - Idle or sleep entered only by the sleep command, per idle bit.
// - Idle bit set: CPU clock stops, peripherals stay clocked.
// - Idle bit clear: all clocks stop; run modes clock both.
// - Clock source select field clears on every reset.
// - Start-up timer counts 1024 primary cycles in crystal modes.
// - Two old rises, hold low, two new rises, release on new fall.
`timescale 1ns/100ps
`default_nettype none
module fsc_top
  import fsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        pri_clk,
  input  wire logic        sec_clk,
  input  wire logic        hf_clk,
  input  wire logic        lf_clk,
  input  wire logic        sec_ready,
  input  wire logic        sleep_exec,
  input  wire logic        wake_event,
  output var  logic        sys_clk,
  output var  fsc_src_t    sys_src,
  output var  logic        cpu_clk_en,
  output var  logic        periph_clk_en,
  output var  logic        clk_fail_irq,
  output var  logic [2:0]  int_freq_sel
);
  logic [3:0]  raw;
  logic [3:0]  prev;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [7:0]  cfg, intc, oscc, tune, peripheral_irq_enable_second, peripheral_irq_flag_second, peripheral_irq_priority_second;
  logic [7:0]  next_cfg, next_intc, next_oscc, next_tune;
  logic [7:0]  next_peripheral_irq_enable_second, next_peripheral_irq_flag_second, next_peripheral_irq_priority_second;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic [7:0]  rd_val;
  logic        hit, wr, scs_toggle, primary_clock_ready, internal_osc_stable;
  logic [4:0]  lf_cnt, next_lf_cnt;
  logic        samp, next_samp, samp_rise, samp_fall;
  logic        det, next_det, armed, fail_det;
  logic [9:0]  ost_cnt, next_ost_cnt;
  logic        ost_done, next_ost_done, ost_expire, ost_restart, needs;
  logic        fs_active, next_fs;
  fsc_src_t    want, tgt, next_tgt, next_cur;
  fsc_sw_t     sw_state, next_sw_state;
  logic        sw_cnt, next_sw_cnt, hold, next_hold;
  logic        tgt_ready, old_dead, monitor_enable_fuse;
  fsc_pwr_t    pwr, next_pwr;

  // Per-source edge detection on the sampled clock levels
  assign raw = {lf_clk, hf_clk, sec_clk, pri_clk};
  for (genvar i = 0; i < 4; i++) begin : g_edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev[i] <= 1'b0;
      end else begin
        prev[i] <= raw[i];
      end
    end
    assign rise[i] = raw[i] & ~prev[i];
    assign fall[i] = ~raw[i] & prev[i];
  end

  // Status and decoded controls
  assign monitor_enable_fuse = cfg[CFG_MONITOR_ENABLE_FUSE];
  assign needs = fsc_needs_ost(cfg[3:0]);
  assign wr    = psel & penable & pready & pwrite;
  assign scs_toggle = wr && (paddr == ADDR_OSCC) &&
                      (pwdata[OSC_SOURCE_SELECT_UPPER] != oscc[OSC_SOURCE_SELECT_UPPER]);
  // ready bit shows the switchover finished
  assign primary_clock_ready = (sys_src == SRC_PRI) & ost_done & ~fs_active &
                (pwr != PWR_SLEEP);
  assign internal_osc_stable = (sys_src == SRC_INT) & (pwr != PWR_SLEEP);

  // Register file: one wait state, so read data is ready with pready
  always_comb begin
    next_cfg = cfg;
    next_intc = intc;
    next_oscc = oscc;
    next_tune = tune;
    next_peripheral_irq_enable_second = peripheral_irq_enable_second;
    next_peripheral_irq_flag_second = peripheral_irq_flag_second;
    next_peripheral_irq_priority_second = peripheral_irq_priority_second;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_pready = psel & penable & ~pready;
    hit = 1'b1;
    case (paddr)
      ADDR_CFG:  rd_val = cfg;
      ADDR_INTC: rd_val = intc;
      ADDR_OSCC: rd_val = {oscc[7:4], primary_clock_ready, internal_osc_stable, oscc[1:0]};
      ADDR_TUNE: rd_val = tune;
      ADDR_PERIPHERAL_IRQ_ENABLE_SECOND: rd_val = peripheral_irq_enable_second;
      ADDR_PERIPHERAL_IRQ_FLAG_SECOND: rd_val = peripheral_irq_flag_second;
      ADDR_PERIPHERAL_IRQ_PRIORITY_SECOND: rd_val = peripheral_irq_priority_second;
      default: begin
        rd_val = 8'h00;
        hit = 1'b0;
      end
    endcase
    if (psel & penable & ~pready) begin
      next_prdata = {24'h000000, rd_val};
      next_pslverr = ~hit;
    end
    if (wr) begin
      case (paddr)
        ADDR_CFG:  next_cfg = {pwdata[7:6], 2'b00, pwdata[3:0]};
        ADDR_INTC: next_intc = pwdata[7:0];
        // Status bits are live, never stored
        ADDR_OSCC: next_oscc = {pwdata[7:4], 2'b00, pwdata[1:0]};
        ADDR_TUNE: next_tune = pwdata[7:0];
        ADDR_PERIPHERAL_IRQ_ENABLE_SECOND: next_peripheral_irq_enable_second = pwdata[7:0];
        // flag write is independent of fail-safe state
        ADDR_PERIPHERAL_IRQ_FLAG_SECOND: next_peripheral_irq_flag_second = pwdata[7:0];
        ADDR_PERIPHERAL_IRQ_PRIORITY_SECOND: next_peripheral_irq_priority_second = pwdata[7:0];
        default: next_cfg = cfg;
      endcase
    end
    // failure set wins over a same-cycle software clear
    if (fail_det) begin
      next_peripheral_irq_flag_second[OSCF_BIT] = 1'b1;
    end
  end

  // Register file state; source select clears on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= RST_CFG;
      intc <= RST_INTC;
      oscc <= RST_OSCC;
      tune <= RST_TUNE;
      peripheral_irq_enable_second <= RST_PERIPHERAL_IRQ_ENABLE_SECOND;
      peripheral_irq_flag_second <= RST_PERIPHERAL_IRQ_FLAG_SECOND;
      peripheral_irq_priority_second <= RST_PERIPHERAL_IRQ_PRIORITY_SECOND;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      clk_fail_irq <= 1'b0;
      int_freq_sel <= RST_OSCC[6:4];
    end else begin
      cfg <= next_cfg;
      intc <= next_intc;
      oscc <= next_oscc;
      tune <= next_tune;
      peripheral_irq_enable_second <= next_peripheral_irq_enable_second;
      peripheral_irq_flag_second <= next_peripheral_irq_flag_second;
      peripheral_irq_priority_second <= next_peripheral_irq_priority_second;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      clk_fail_irq <= next_peripheral_irq_flag_second[OSCF_BIT] & next_peripheral_irq_enable_second[OSCF_BIT];
      // fallback frequency follows the field at all times
      int_freq_sel <= next_oscc[6:4];
    end
  end

  // Sample-clock divider, detector latch, start-up timer, fail-safe state
  // armed only after timer expiry, with the fuse set
  assign armed = monitor_enable_fuse & ost_done & ~fs_active & (pwr != PWR_SLEEP);
  assign ost_restart = scs_toggle | (wake_event & (pwr == PWR_SLEEP));
  assign samp_rise = next_samp & ~samp;
  assign samp_fall = ~next_samp & samp;
  // a whole half-period since the clearing rise saw no primary fall
  assign fail_det = armed & samp_fall & ~det & ~fall[B_PRI];
  // A restart that is done at once (no timer) still counts as an expiry,
  // otherwise a toggle in clock-input mode would never clear fail-safe
  assign ost_expire = next_ost_done & (~ost_done | ost_restart);
  always_comb begin
    next_lf_cnt = lf_cnt;
    next_samp = samp;
    // toggle every 32 low-frequency rises, period of 64
    if (rise[B_LF]) begin
      if (lf_cnt == LF_HALF_LAST) begin
        next_lf_cnt = 5'h00;
        next_samp = ~samp;
      end else begin
        next_lf_cnt = lf_cnt + 5'h01;
      end
    end
    // set on primary fall wins over clear on sample rise
    next_det = det;
    if (samp_rise) begin
      next_det = 1'b0;
    end
    if (fall[B_PRI]) begin
      next_det = 1'b1;
    end
    next_ost_cnt = ost_cnt;
    next_ost_done = ost_done;
    if (ost_restart) begin
      next_ost_cnt = 10'h000;
      // no timer for clock-input and RC modes
      next_ost_done = ~needs;
    end else if (pwr == PWR_SLEEP) begin
      next_ost_cnt = 10'h000;
      next_ost_done = 1'b0;
    end else if (!ost_done) begin
      if (!needs) begin
        next_ost_done = 1'b1;
      end else if (fall[B_PRI]) begin
        if (ost_cnt == OST_LAST) begin
          next_ost_done = 1'b1;
        end else begin
          next_ost_cnt = ost_cnt + 10'h001;
        end
      end
    end
    next_fs = fs_active;
    if (ost_expire) begin
      next_fs = 1'b0;
    end
    // failure enters fail-safe; armed only with the fuse set
    if (fail_det) begin
      next_fs = 1'b1;
    end
  end

  // Monitor state; fail-safe cleared by reset as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_cnt <= 5'h00;
      samp <= 1'b0;
      det <= 1'b0;
      ost_cnt <= 10'h000;
      ost_done <= 1'b0;
      // any reset clears the fail-safe state
      fs_active <= 1'b0;
    end else begin
      lf_cnt <= next_lf_cnt;
      samp <= next_samp;
      det <= next_det;
      ost_cnt <= next_ost_cnt;
      ost_done <= next_ost_done;
      fs_active <= next_fs;
    end
  end

  // Source wanted by software and fail-safe state
  always_comb begin
    if (oscc[OSC_SOURCE_SELECT_UPPER]) begin
      want = SRC_INT;
    end else if (oscc[OSC_SCS0]) begin
      want = SRC_SEC;
    // primary only once the state is cleared by the timer
    end else if (ost_done & ~fs_active) begin
      want = SRC_PRI;
    end else if (cfg[CFG_TWO_SPEED_ENABLE_FUSE] | monitor_enable_fuse | fs_active) begin
      want = SRC_INT;
    end else begin
      want = SRC_PRI;
    end
    case (tgt)
      SRC_PRI: tgt_ready = ost_done & ~fs_active;
      SRC_SEC: tgt_ready = sec_ready;
      default: tgt_ready = 1'b1;
    endcase
  end

  // A failed primary gives no edges, so its half of the handshake is skipped
  assign old_dead = (sys_src == SRC_PRI) & fs_active;

  // Clock switch sequencer
  always_comb begin
    next_sw_state = sw_state;
    next_tgt = tgt;
    next_sw_cnt = sw_cnt;
    next_hold = hold;
    next_cur = sys_src;
    case (sw_state)
      SW_IDLE: begin
        if (want != sys_src) begin
          next_tgt = want;
          next_sw_state = SW_READY;
        end
      end
      // a running target passes this state at once
      SW_READY: begin
        next_sw_cnt = 1'b0;
        if (want != tgt) begin
          next_tgt = want;
          if (want == sys_src) begin
            next_sw_state = SW_IDLE;
          end
        end else if (tgt_ready) begin
          if (old_dead) begin
            next_hold = 1'b1;
            next_sw_state = SW_NEW;
          end else begin
            next_sw_state = SW_OLD;
          end
        end
      end
      // two rises of the old clock
      SW_OLD: begin
        if (old_dead) begin
          next_hold = 1'b1;
          next_sw_state = SW_NEW;
        end else if (rise[sys_src]) begin
          if (sw_cnt == EDGE_LAST) begin
            next_sw_state = SW_HOLD;
          end else begin
            next_sw_cnt = 1'b1;
          end
        end
      end
      // hold low from an old falling edge, so no runt pulse
      SW_HOLD: begin
        if (fall[sys_src] | old_dead) begin
          next_hold = 1'b1;
          next_sw_cnt = 1'b0;
          next_sw_state = SW_NEW;
        end
      end
      // two rises of the new clock
      SW_NEW: begin
        if (rise[tgt]) begin
          if (sw_cnt == EDGE_LAST) begin
            next_sw_state = SW_REL;
          end else begin
            next_sw_cnt = 1'b1;
          end
        end
      end
      // release on the next falling edge of the new clock
      SW_REL: begin
        if (fall[tgt]) begin
          next_hold = 1'b0;
          next_cur = tgt;
          next_sw_state = SW_IDLE;
        end
      end
      default: next_sw_state = SW_IDLE;
    endcase
  end

  // Power mode selection from the sleep command
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      // only the sleep command leaves run
      PWR_RUN: begin
        if (sleep_exec) begin
          next_pwr = oscc[OSC_IDLE_ON_SLEEP] ? PWR_IDLE : PWR_SLEEP;
        end
      end
      PWR_IDLE, PWR_SLEEP: begin
        if (wake_event) begin
          next_pwr = PWR_RUN;
        end
      end
      default: next_pwr = PWR_RUN;
    endcase
  end

  // Switch and power state; reset starts on the internal block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= SW_IDLE;
      tgt <= SRC_INT;
      sw_cnt <= 1'b0;
      hold <= 1'b0;
      sys_src <= SRC_INT;
      pwr <= PWR_RUN;
      sys_clk <= 1'b0;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
    end else begin
      sw_state <= next_sw_state;
      tgt <= next_tgt;
      sw_cnt <= next_sw_cnt;
      hold <= next_hold;
      sys_src <= next_cur;
      pwr <= next_pwr;
      sys_clk <= raw[next_cur] & ~next_hold & (next_pwr != PWR_SLEEP);
      cpu_clk_en <= (next_pwr == PWR_RUN);
      periph_clk_en <= (next_pwr != PWR_SLEEP);
    end
  end

  sequence s_hold_start;
    (sw_state == SW_HOLD) && fall[sys_src];
  endsequence
  sequence s_clk_low;
    !sys_clk [*2];
  endsequence

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !peripheral_irq_enable_second[OSCF_BIT] && !wr |=> !clk_fail_irq)
    else $error("interrupt without its enable");
  a_fail_flag: assert property (@(posedge pclk) disable iff (!presetn)
    fail_det |=> peripheral_irq_flag_second[OSCF_BIT] && fs_active)
    else $error("failure did not set flag and state");
  a_fail_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fail_det |-> ost_done && monitor_enable_fuse && samp_fall)
    else $error("failure flagged before timer expiry");
  a_no_back: assert property (@(posedge pclk) disable iff (!presetn)
    fs_active && $past(fs_active) && $rose(sw_state == SW_READY)
    |-> tgt != SRC_PRI)
    else $error("automatic return to failed primary");
  a_ost_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ost_done) && needs && !$past(ost_restart)
    |-> $past(ost_cnt) == OST_LAST)
    else $error("timer expired at wrong count");
  a_ost_skip: assert property (@(posedge pclk) disable iff (!presetn)
    ost_restart && !needs |=> ost_done)
    else $error("timer not skipped");
  a_fs_clear: assert property (@(posedge pclk) disable iff (!presetn)
    fs_active && ost_expire && !fail_det |=> !fs_active)
    else $error("expiry did not clear fail-safe");
  a_idle_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr == PWR_RUN) && sleep_exec && oscc[OSC_IDLE_ON_SLEEP]
    |=> !cpu_clk_en && periph_clk_en)
    else $error("idle entry wrong");
  a_sleep_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr == PWR_RUN) && sleep_exec && !oscc[OSC_IDLE_ON_SLEEP]
    |=> !cpu_clk_en && !periph_clk_en && !sys_clk)
    else $error("sleep entry wrong");
  a_hold_low: assert property (@(posedge pclk) disable iff (!presetn)
    s_hold_start |=> s_clk_low)
    else $error("system clock not held low");
  a_flag_clr: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == ADDR_PERIPHERAL_IRQ_FLAG_SECOND) && !pwdata[OSCF_BIT] && !fail_det
    |=> !peripheral_irq_flag_second[OSCF_BIT])
    else $error("flag not cleared by zero write");
endmodule
`default_nettype wire

// [dv/fsc_osc_model.sv]
// Oscillator sources seen as levels sampled on the bus clock
`timescale 1ns/100ps
`default_nettype none
module fsc_osc_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic primary_run,
  output var  logic pri_clk,
  output var  logic sec_clk,
  output var  logic hf_clk,
  output var  logic lf_clk,
  output var  logic sec_ready
);
  logic [3:0] div;

  // Free-running dividers; a stopped primary freezes like a dead crystal,
  // so the monitor sees no further falling edges from it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div       <= 4'h0;
      pri_clk   <= 1'b0;
      sec_clk   <= 1'b0;
      hf_clk    <= 1'b0;
      lf_clk    <= 1'b0;
      sec_ready <= 1'b0;
    end else begin
      div       <= div + 4'h1;
      hf_clk    <= ~hf_clk;
      lf_clk    <= ~lf_clk;
      sec_clk   <= div[2];
      // Secondary needs a short start-up before it reports running
      sec_ready <= sec_ready | (div == 4'hf);
      if (primary_run && div[0]) begin
        pri_clk <= ~pri_clk;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the fail-safe clock and power block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fsc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        sleep_exec = 1'b0;
  logic        wake_event = 1'b0;
  logic        primary_run = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pri_clk;
  logic        sec_clk;
  logic        hf_clk;
  logic        lf_clk;
  logic        sec_ready;
  logic        sys_clk;
  fsc_src_t    sys_src;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        clk_fail_irq;
  logic [2:0]  int_freq_sel;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0;
  int          samples_checked = 0;
  localparam logic [7:0] RA [7] = '{ADDR_CFG, ADDR_INTC, ADDR_OSCC,
    ADDR_TUNE, ADDR_PERIPHERAL_IRQ_ENABLE_SECOND, ADDR_PERIPHERAL_IRQ_FLAG_SECOND, ADDR_PERIPHERAL_IRQ_PRIORITY_SECOND};
  localparam logic [7:0] RV [7] = '{RST_CFG, RST_INTC, RST_OSCC,
    RST_TUNE, RST_PERIPHERAL_IRQ_ENABLE_SECOND, RST_PERIPHERAL_IRQ_FLAG_SECOND, RST_PERIPHERAL_IRQ_PRIORITY_SECOND};

  always #20 pclk = ~pclk;

  fsc_osc_model osc (.pclk(pclk), .presetn(presetn), .primary_run(primary_run),
    .pri_clk(pri_clk), .sec_clk(sec_clk), .hf_clk(hf_clk),
    .lf_clk(lf_clk), .sec_ready(sec_ready));

  fsc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pri_clk(pri_clk), .sec_clk(sec_clk), .hf_clk(hf_clk),
    .lf_clk(lf_clk), .sec_ready(sec_ready), .sleep_exec(sleep_exec),
    .wake_event(wake_event), .sys_clk(sys_clk), .sys_src(sys_src),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .clk_fail_irq(clk_fail_irq), .int_freq_sel(int_freq_sel));

  // Closing verdict, shared by the main sequence and the watchdog
  task automatic wrap_up();
    $display("Counts: %0d checked, %0d mismatched", samples_checked,
             fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits on pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait for a clock source, then one comparison
  task automatic wait_src(input fsc_src_t s, input int lim);
    int n = 0;
    while (sys_src !== s && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("sys_src", 32'(s), 32'(sys_src));
  endtask

  // Counts cycles off the expected source; a brief wander also fails
  task automatic hold_src(input fsc_src_t s, input int cyc);
    int bad = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (sys_src !== s) bad++;
    end
    chk("cycles off source", 32'h0, 32'(bad));
  endtask

  // Pulse sleep or wake, then let the enables settle
  task automatic pm(input logic slp, input logic [1:0] exp);
    if (slp) sleep_exec <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
    wake_event <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("cpu/periph enables", 32'(exp), {30'h0, cpu_clk_en, periph_clk_en});
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk("reset value", 32'(RV[i]), rd & ((i == 2) ? 32'hf3 : '1));
    end
    chk("int_freq_sel", 32'(RST_OSCC[6:4]), 32'(int_freq_sel));
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    $display("test reset done");
    // Fuse on, crystal mode: internal clock while the timer counts
    apb(1'b1, ADDR_CFG, 32'h41);
    hold_src(SRC_INT, 3800);
    wait_src(SRC_PRI, 1000);
    apb(1'b0, ADDR_OSCC, 32'h0);
    chk("ready bit", 32'h8, rd & 32'h8);
    $display("test startup done");
    // Fallback frequency is chosen before the failure
    apb(1'b1, ADDR_OSCC, 32'h50);
    @(posedge pclk);
    chk("int_freq_sel", 32'h5, 32'(int_freq_sel));
    primary_run <= 1'b0;
    wait_src(SRC_INT, 400);
    apb(1'b0, ADDR_PERIPHERAL_IRQ_FLAG_SECOND, 32'h0);
    chk("fail flag", 32'h80, rd & 32'h80);
    chk("masked irq", 32'h0, 32'(clk_fail_irq));
    apb(1'b1, ADDR_PERIPHERAL_IRQ_ENABLE_SECOND, 32'h80);
    repeat (2) @(posedge pclk);
    chk("enabled irq", 32'h1, 32'(clk_fail_irq));
    primary_run <= 1'b1;
    hold_src(SRC_INT, 5000);
    apb(1'b1, ADDR_PERIPHERAL_IRQ_FLAG_SECOND, 32'h0);
    apb(1'b0, ADDR_PERIPHERAL_IRQ_FLAG_SECOND, 32'h0);
    chk("cleared flag", 32'h0, rd & 32'h80);
    chk("cleared irq", 32'h0, 32'(clk_fail_irq));
    chk("still internal", 32'(SRC_INT), 32'(sys_src));
    $display("test failure done");
    // Toggling the upper select bit restarts the timer
    apb(1'b1, ADDR_OSCC, 32'h52);
    apb(1'b1, ADDR_OSCC, 32'h50);
    hold_src(SRC_INT, 3500);
    wait_src(SRC_PRI, 1500);
    $display("test clearing done");
    apb(1'b1, ADDR_OSCC, 32'h51);
    wait_src(SRC_SEC, 300);
    apb(1'b1, ADDR_OSCC, 32'h52);
    wait_src(SRC_INT, 300);
    $display("test sources done");
    apb(1'b1, ADDR_OSCC, 32'hd2);
    repeat (2) @(posedge pclk);
    chk("run enables", 32'h3, {30'h0, cpu_clk_en, periph_clk_en});
    pm(1'b1, 2'b01);
    pm(1'b0, 2'b11);
    apb(1'b1, ADDR_OSCC, 32'h52);
    pm(1'b1, 2'b00);
    chk("sleep clock", 32'h0, 32'(sys_clk));
    pm(1'b0, 2'b11);
    $display("test power done");
    // A reset in mid-run clears the select field
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_OSCC, 32'h0);
    chk("select after reset", 32'h0, rd & 32'h3);
    chk("source after reset", 32'(SRC_INT), 32'(sys_src));
    $display("test rereset done");
    // Clock-input mode: no timer, monitor active at once, toggle clears
    apb(1'b1, ADDR_CFG, 32'h44);
    wait_src(SRC_PRI, 200);
    primary_run <= 1'b0;
    wait_src(SRC_INT, 400);
    primary_run <= 1'b1;
    apb(1'b1, ADDR_OSCC, 32'h32);
    apb(1'b1, ADDR_OSCC, 32'h30);
    wait_src(SRC_PRI, 200);
    // Fuse off: a dead primary is never flagged
    apb(1'b1, ADDR_CFG, 32'h04);
    primary_run <= 1'b0;
    hold_src(SRC_PRI, 400);
    $display("test clock input done");
    wrap_up();
  end

  // Watchdog: the tests need about 14000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
